/* File: logic/spcb_pkg.sv */
// package for the serial port control and buffer block
// assumes an apb slave in front and an external serial clock/frame device
package spcb_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTL     = 8'h00;
  localparam logic [7:0] OFF_TX_A    = 8'h04;
  localparam logic [7:0] OFF_TX_B    = 8'h08;
  localparam logic [7:0] OFF_RX_A    = 8'h0C;
  localparam logic [7:0] OFF_RX_B    = 8'h10;
  localparam logic [7:0] OFF_MCTL    = 8'h14;
  // control field positions
  localparam int B_EN_A    = 0;
  localparam int B_LOW_BIT_FIRST    = 3;
  localparam int B_WORD_LENGTH_FIELD    = 4;
  localparam int B_OPERATING_MODE_SELECT  = 11;
  localparam int B_CLOCK_EDGE_SELECT    = 12;
  localparam int B_FSR     = 13;
  localparam int B_LFS     = 16;
  localparam int B_DMA_A   = 18;
  localparam int B_DMA_B   = 20;
  localparam int B_BHD     = 23;
  localparam int B_EN_B    = 24;
  localparam int B_DIR     = 25;
  localparam int B_ERR_B   = 26;
  localparam int B_STS_B   = 27;
  localparam int B_ERR_A   = 29;
  localparam int B_STS_A   = 30;
  // writable control bits 0..25
  localparam logic [31:0] CTL_WMASK  = 32'h03FFFFFF;
  localparam logic [31:0] CTL_RESET  = 32'h00000000;
  localparam logic [31:0] MCTL_WMASK = 32'h00FFFFFF;
  localparam logic [31:0] MCTL_RESET = 32'h00000000;
  // buffer status codes
  localparam logic [1:0] STS_EMPTY = 2'h0;
  localparam logic [1:0] STS_PART  = 2'h2;
  localparam logic [1:0] STS_FULL  = 2'h3;
endpackage : spcb_pkg

/* File: logic/spcb_chan_if.sv */
// interface between the port core and one channel shifter
// assumes a single system clock
`timescale 1ns/1ps
`default_nettype none
interface spcb_chan_if;
  logic        tx_mode;   // direction transmit
  logic        enable;    // channel enabled
  logic [4:0]  word_length_field;      // word length minus one
  logic        lsb_first;
  logic        bit_edge;  // shifting edge strobe
  logic        frame;     // frame start strobe
  logic        frame_req; // frame sync required
  logic        din;       // synchronised data line
  logic        load_ok;   // tx word available
  logic [31:0] load_word;
  logic        load_take; // shifter took the word
  logic        tx_starve; // frame with nothing to send
  logic        dout;
  logic        rx_done;   // pulse: word complete
  logic [31:0] rx_word;
  modport core  (output tx_mode, enable, word_length_field, lsb_first, bit_edge, frame, frame_req, din,
                 load_ok, load_word, input load_take, tx_starve, dout, rx_done, rx_word);
  modport shift (input tx_mode, enable, word_length_field, lsb_first, bit_edge, frame, frame_req, din,
                 load_ok, load_word, output load_take, tx_starve, dout, rx_done, rx_word);
endinterface : spcb_chan_if
`default_nettype wire

/* File: logic/spcb_shifter.sv */
// one channel shift register, transmit or receive
// assumes a one-cycle edge strobe from the core; frame stays high until the next shifting edge
`timescale 1ns/1ps
`default_nettype none
module spcb_shifter (
  input  wire logic    clk,
  input  wire logic    rst_n,
  spcb_chan_if.shift   ch
);
  typedef struct packed {
    logic [31:0] sr;
    logic [4:0]  cnt;
    logic        busy;
    logic        dout;
    logic        take;
    logic        starve;
    logic        done;
    logic [31:0] word;
  } spcb_sh_t;
  spcb_sh_t s_q, s_d;

  // bit sequencing for both directions
  always_comb begin
    s_d        = s_q;
    s_d.take   = 1'b0;
    s_d.starve = 1'b0;
    s_d.done   = 1'b0;
    if (!ch.enable) begin
      s_d.busy = 1'b0;
      s_d.cnt  = 5'h00;
    end else if (ch.bit_edge) begin
      if (ch.tx_mode) begin
        if (!s_q.busy && (ch.frame || !ch.frame_req)) begin
          if (ch.load_ok) begin
            s_d.sr   = ch.load_word;
            s_d.take = 1'b1;
            s_d.busy = 1'b1;
            s_d.cnt  = 5'h00;
            s_d.dout = ch.lsb_first ? ch.load_word[0] : ch.load_word[ch.word_length_field];
          end else begin
            s_d.starve = 1'b1;
          end
        end else if (s_q.busy) begin
          if (s_q.cnt == ch.word_length_field) begin
            s_d.busy = 1'b0;
          end else begin
            s_d.cnt  = s_q.cnt + 5'h01;
            s_d.dout = ch.lsb_first ? s_q.sr[s_q.cnt + 5'h01] : s_q.sr[ch.word_length_field - s_q.cnt - 5'h01];
          end
        end
      end else if (s_q.busy || ch.frame || !ch.frame_req) begin
        if (!s_q.busy) begin
          s_d.sr  = 32'h00000000;
          s_d.cnt = 5'h00;
        end
        if (ch.lsb_first) begin
          s_d.sr[s_d.cnt] = ch.din;
        end else begin
          s_d.sr = {s_d.sr[30:0], ch.din};
        end
        s_d.busy = 1'b1;
        s_d.cnt  = s_d.cnt + 5'h01;
        if (s_d.cnt - 5'h01 == ch.word_length_field) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.word = s_d.sr;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.load_take = s_q.take;
  assign ch.tx_starve = s_q.starve;
  assign ch.dout      = s_q.dout;
  assign ch.rx_done   = s_q.done;
  assign ch.rx_word   = s_q.word;
endmodule : spcb_shifter
`default_nettype wire

/* File: logic/spcb_port.sv */
// serial port control register, transmit/receive buffers, apb slave
// assumes serial clock and frame sync arrive from the pins, asynchronous
//
// Notes on behaviour
// - one 32-bit control register and 32-bit buffers for channels A and B.
// - word length, packing, mode, dma, chaining and hang-disable fields fixed.
// - standard mode bit map: enables, type, order, clock, framing, direction.
// - i2s/left-justified: bit 10 master, bit 16 left first; some bits reserved.
// - multichannel: bit 16 data-valid control; enables and direction elsewhere. Not built here: bit 16 stays the frame level.
// - status in bits 26 to 31: errors and buffer status per channel.
// - one shared multichannel control and status register per pair.
// - only buffers of the selected direction are active.
// - short words held right-justified in both buffers.
// - transmit queues two words: data register plus shifter.
// - data register moves into an idle shifter automatically.
// - transmit interrupt on shifter load unless dma on or masked.
// - transmit companding only on channel A of even ports; not built here, the A word passes as written.
// - transmit shifter drives data on serial clock; frame marks word start.
// - an enabled transmit data line is driven continuously.
// - in transmit direction receive buffers ignore clocks and report empty.
// - in receive direction complete words copied into the receive buffer.
// - receive shifter samples data on serial clock; frame marks word start.
// - receive expansion only on channel A of odd ports; B goes direct. Not built here: A goes direct too.
// - status codes: 00 empty, 01 reserved, 10 partial, 11 full.
// - error bits are sticky; each clears only when its own channel enable (bit 0 for A, bit 24 for B) is cleared.
`timescale 1ns/1ps
`default_nettype none
module spcb_port #(
  parameter bit ODD_PORT = 1'b0  // pair position: not used, A transmits as written
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        SERIAL_BIT_CLOCK_IN,
  input  wire logic        FRAME_SYNC_LINE_IN,
  input  wire logic        DATA_LINE_A_IN,
  input  wire logic        DATA_LINE_B_IN,
  output logic             DATA_LINE_A_OUT,
  output logic             DATA_LINE_A_OE_OUT,
  output logic             DATA_LINE_B_OUT,
  output logic             DATA_LINE_B_OE_OUT,
  input  wire logic        TX_INT_MASK_IN,
  output logic             TX_INT_OUT
);
  typedef struct packed {
    logic [31:0] buf0;   // oldest / transmit data register
    logic [31:0] buf1;   // second receive slot
    logic [1:0]  cnt;    // words held
    logic        err;
  } spcb_buf_t;

  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] mctl;
    spcb_buf_t   a;
    spcb_buf_t   b;
    logic [2:0]  clk_s;  // two sync stages plus history
    logic [1:0]  fs_s;
    logic [1:0]  da_s;
    logic [1:0]  db_s;
    logic        fs_prev;
    logic [31:0] rdata;
    logic        tx_int;
  } spcb_state_t;

  spcb_state_t st_q, st_d;
  spcb_chan_if ch_a ();
  spcb_chan_if ch_b ();

  spcb_shifter u_sh_a (.clk(CLK_SYS_IN), .rst_n(RST_N_IN), .ch(ch_a));
  spcb_shifter u_sh_b (.clk(CLK_SYS_IN), .rst_n(RST_N_IN), .ch(ch_b));

  // status code from occupancy
  function automatic logic [1:0] sts_code(input logic [1:0] cnt, input logic is_tx);
    if (cnt == 2'h0) begin
      sts_code = spcb_pkg::STS_EMPTY;
    end else if (is_tx || cnt == 2'h2) begin
      sts_code = spcb_pkg::STS_FULL;
    end else begin
      sts_code = spcb_pkg::STS_PART;
    end
  endfunction : sts_code

  // push a received word, overwriting the second slot when full
  function automatic spcb_buf_t rx_push(input spcb_buf_t b, input logic [31:0] w);
    rx_push = b;
    if (b.cnt == 2'h0) begin
      rx_push.buf0 = w;
      rx_push.cnt  = 2'h1;
    end else begin
      rx_push.buf1 = w;
      rx_push.cnt  = 2'h2;
      if (b.cnt == 2'h2) begin
        rx_push.err = 1'b1;
      end
    end
  endfunction : rx_push

  logic        tx_dir;
  logic        en_a;
  logic        en_b;
  logic        mc_mode;
  logic        edge_rise;
  logic        edge_shift;
  logic        frame_pulse;
  logic        fs_level;
  logic        access;
  logic        hang;
  logic        i2s_mode;

  // direction and enables, fixed in multichannel
  assign mc_mode = 1'b0;  // multichannel sequencing not built here
  assign tx_dir  = st_q.ctl[spcb_pkg::B_DIR];
  assign en_a    = st_q.ctl[spcb_pkg::B_EN_A];
  assign en_b    = st_q.ctl[spcb_pkg::B_EN_B];

  // i2s and left-justified: order bit reserved, framing always used
  assign i2s_mode = st_q.ctl[spcb_pkg::B_OPERATING_MODE_SELECT];

  // serial clock edges and frame start from synchronised pins
  assign edge_rise   = st_q.clk_s[1] & ~st_q.clk_s[2];
  assign edge_shift  = st_q.ctl[spcb_pkg::B_CLOCK_EDGE_SELECT] ? edge_rise : (~st_q.clk_s[1] & st_q.clk_s[2]);
  // bit 16 also picks the starting level; raw history, so no false frame
  assign fs_level    = st_q.fs_s[1] ^ st_q.ctl[spcb_pkg::B_LFS];
  assign frame_pulse = fs_level & ~(st_q.fs_prev ^ st_q.ctl[spcb_pkg::B_LFS]);

  // channel wiring: shared fields, only the selected direction shifts
  always_comb begin
    ch_a.tx_mode   = tx_dir;
    ch_a.enable    = en_a;
    ch_a.word_length_field      = st_q.ctl[spcb_pkg::B_WORD_LENGTH_FIELD +: 5];
    ch_a.lsb_first = st_q.ctl[spcb_pkg::B_LOW_BIT_FIRST] & ~i2s_mode;
    ch_a.bit_edge  = edge_shift;
    ch_a.frame     = frame_pulse;
    ch_a.frame_req = st_q.ctl[spcb_pkg::B_FSR] | i2s_mode;
    ch_a.din       = st_q.da_s[1];
    // companding path left transparent; A word passes as written
    ch_a.load_ok   = tx_dir && (st_q.a.cnt != 2'h0);
    ch_a.load_word = st_q.a.buf0;
    ch_b.tx_mode   = tx_dir;
    ch_b.enable    = en_b;
    ch_b.word_length_field      = st_q.ctl[spcb_pkg::B_WORD_LENGTH_FIELD +: 5];
    ch_b.lsb_first = st_q.ctl[spcb_pkg::B_LOW_BIT_FIRST] & ~i2s_mode;
    ch_b.bit_edge  = edge_shift;
    ch_b.frame     = frame_pulse;
    ch_b.frame_req = st_q.ctl[spcb_pkg::B_FSR] | i2s_mode;
    ch_b.din       = st_q.db_s[1];
    ch_b.load_ok   = tx_dir && (st_q.b.cnt != 2'h0);
    ch_b.load_word = st_q.b.buf0;
  end

  // register read value, status bits from the active buffers
  function automatic logic [31:0] read_word(input spcb_state_t s, input logic [7:0] a);
    logic tx;
    tx        = s.ctl[spcb_pkg::B_DIR];
    read_word = 32'h00000000;
    if (a == spcb_pkg::OFF_CTL) begin
      read_word                         = s.ctl;
      read_word[spcb_pkg::B_ERR_B]      = s.b.err;
      read_word[spcb_pkg::B_STS_B +: 2] = sts_code(s.b.cnt, tx);
      read_word[spcb_pkg::B_ERR_A]      = s.a.err;
      read_word[spcb_pkg::B_STS_A +: 2] = sts_code(s.a.cnt, tx);
    end else if (a == spcb_pkg::OFF_MCTL) begin
      read_word = s.mctl;
    end else if (a == spcb_pkg::OFF_RX_A) begin
      read_word = s.a.buf0;
    end else if (a == spcb_pkg::OFF_RX_B) begin
      read_word = s.b.buf0;
    end
  endfunction : read_word

  assign access = PSEL_IN & PENABLE_IN;

  // core hang: read of empty receive buffer, or write to full transmit buffer
  always_comb begin
    hang = 1'b0;
    if (PADDR_IN == spcb_pkg::OFF_RX_A) begin
      hang = !PWRITE_IN && st_q.a.cnt == 2'h0 && !st_q.ctl[spcb_pkg::B_BHD];
    end else if (PADDR_IN == spcb_pkg::OFF_RX_B) begin
      hang = !PWRITE_IN && st_q.b.cnt == 2'h0 && !st_q.ctl[spcb_pkg::B_BHD];
    end else if (PADDR_IN == spcb_pkg::OFF_TX_A) begin
      hang = PWRITE_IN && st_q.a.cnt != 2'h0 && !st_q.ctl[spcb_pkg::B_BHD];
    end else if (PADDR_IN == spcb_pkg::OFF_TX_B) begin
      hang = PWRITE_IN && st_q.b.cnt != 2'h0 && !st_q.ctl[spcb_pkg::B_BHD];
    end
  end

  // next state
  always_comb begin
    st_d         = st_q;
    st_d.clk_s   = {st_q.clk_s[1:0], SERIAL_BIT_CLOCK_IN};
    st_d.fs_s    = {st_q.fs_s[0], FRAME_SYNC_LINE_IN};
    st_d.da_s    = {st_q.da_s[0], DATA_LINE_A_IN};
    st_d.db_s    = {st_q.db_s[0], DATA_LINE_B_IN};
    st_d.fs_prev = (edge_shift || !(en_a || en_b)) ? st_q.fs_s[1] : st_q.fs_prev;
    st_d.tx_int  = 1'b0;

    if (ch_a.load_take) begin
      st_d.a.cnt = 2'h0;
    end
    if (ch_b.load_take) begin
      st_d.b.cnt = 2'h0;
    end
    st_d.tx_int = (ch_a.load_take & ~st_q.ctl[spcb_pkg::B_DMA_A])
                | (ch_b.load_take & ~st_q.ctl[spcb_pkg::B_DMA_B]);
    if (TX_INT_MASK_IN) begin
      st_d.tx_int = 1'b0;
    end
    if (ch_a.tx_starve) begin
      st_d.a.err = 1'b1;
    end
    if (ch_b.tx_starve) begin
      st_d.b.err = 1'b1;
    end
    // received words straight into the buffer
    if (!tx_dir && ch_a.rx_done) begin
      st_d.a = rx_push(st_d.a, ch_a.rx_word);
    end
    if (!tx_dir && ch_b.rx_done) begin
      st_d.b = rx_push(st_d.b, ch_b.rx_word);
    end

    // apb access phase
    if (access && !hang) begin
      if (PWRITE_IN) begin
        if (PADDR_IN == spcb_pkg::OFF_CTL) begin
          st_d.ctl = PWDATA_IN & spcb_pkg::CTL_WMASK;
        end else if (PADDR_IN == spcb_pkg::OFF_MCTL) begin
          st_d.mctl = PWDATA_IN & spcb_pkg::MCTL_WMASK;
        end else if (PADDR_IN == spcb_pkg::OFF_TX_A) begin
          // data register takes a right-justified word
          st_d.a.buf0 = PWDATA_IN;
          st_d.a.cnt  = 2'h1;
        end else if (PADDR_IN == spcb_pkg::OFF_TX_B) begin
          st_d.b.buf0 = PWDATA_IN;
          st_d.b.cnt  = 2'h1;
        end
      end else begin
        // receive slots pop at the taking edge; the word was staged before it
        if (PADDR_IN == spcb_pkg::OFF_RX_A) begin
          st_d.a.buf0 = st_d.a.cnt == 2'h2 ? st_d.a.buf1 : st_d.a.buf0;
          st_d.a.cnt  = st_d.a.cnt - 2'h1;
        end else if (PADDR_IN == spcb_pkg::OFF_RX_B) begin
          st_d.b.buf0 = st_d.b.cnt == 2'h2 ? st_d.b.buf1 : st_d.b.buf0;
          st_d.b.cnt  = st_d.b.cnt - 2'h1;
        end
      end
    end

    if (!st_d.ctl[spcb_pkg::B_EN_A]) begin
      st_d.a.err = 1'b0;
    end
    if (!st_d.ctl[spcb_pkg::B_EN_B]) begin
      st_d.b.err = 1'b0;
    end

    // read data staged while a read waits, so it stands at the edge that takes it
    if (PSEL_IN && !PWRITE_IN && !(access && !hang)) begin
      st_d.rdata = read_word(st_d, PADDR_IN);
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // data lines driven while enabled as transmitter
  assign DATA_LINE_A_OUT    = ch_a.dout;
  assign DATA_LINE_A_OE_OUT = tx_dir & en_a & ~mc_mode;
  assign DATA_LINE_B_OUT    = ch_b.dout;
  assign DATA_LINE_B_OE_OUT = tx_dir & en_b & ~mc_mode;

  assign PRDATA_OUT  = st_q.rdata;
  assign PREADY_OUT  = ~hang;
  assign PSLVERR_OUT = 1'b0;
  assign TX_INT_OUT  = st_q.tx_int;
endmodule : spcb_port
`default_nettype wire

/* File: tb/spcb_port_chk.sv */
// checker for the serial port block, apb side and serial outputs
// assumes it is bound to spcb_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module spcb_port_chk (
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        DATA_LINE_A_OE_OUT,
  input wire logic        DATA_LINE_B_OE_OUT,
  input wire logic        TX_INT_MASK_IN,
  input wire logic        TX_INT_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  logic        tk;    // transfer taken
  logic [31:0] sh_q;  // shadow of the control register
  logic [1:0]  age_q; // cycles since last control write
  assign tk = PSEL_IN && PENABLE_IN && PREADY_OUT;
  // shadow control writes and age them
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sh_q  <= 32'h0;
      age_q <= 2'h0;
    end else if (tk && PWRITE_IN && PADDR_IN == spcb_pkg::OFF_CTL) begin
      sh_q  <= PWDATA_IN & spcb_pkg::CTL_WMASK;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  sequence s_rd(logic [7:0] a);
    tk && !PWRITE_IN && PADDR_IN == a;
  endsequence
  chk_ctl_readback:
    assert property (s_rd(spcb_pkg::OFF_CTL) |-> PRDATA_OUT[25:0] == sh_q[25:0])
    else $error("control readback wrong");
  chk_status_code:
    assert property (s_rd(spcb_pkg::OFF_CTL) |-> PRDATA_OUT[31:30] != 2'h1
                     && PRDATA_OUT[28:27] != 2'h1) else $error("reserved status code");
  chk_err_cleared:
    assert property (s_rd(spcb_pkg::OFF_CTL) |-> (sh_q[0] || !PRDATA_OUT[29])
                     && (sh_q[24] || !PRDATA_OUT[26])) else $error("error bit kept");
  chk_oe_follows:
    assert property (age_q == 2'h3 |-> DATA_LINE_A_OE_OUT == (sh_q[0] && sh_q[25])
                     && DATA_LINE_B_OE_OUT == (sh_q[24] && sh_q[25])) else $error("oe wrong");
  chk_int_pulse:
    assert property (TX_INT_OUT |=> !TX_INT_OUT) else $error("interrupt too long");
  chk_int_masked:
    assert property (TX_INT_MASK_IN && $past(TX_INT_MASK_IN) |-> !TX_INT_OUT)
    else $error("masked interrupt seen");
  chk_int_dma:
    assert property (sh_q[18] && sh_q[20] && age_q == 2'h3 |-> !TX_INT_OUT)
    else $error("interrupt with dma on");
  chk_ctl_no_wait:
    assert property (PSEL_IN && PENABLE_IN && PADDR_IN == spcb_pkg::OFF_CTL |-> PREADY_OUT
                     && !PSLVERR_OUT) else $error("control access stalled");
  chk_unmapped_zero:
    assert property (tk && !PWRITE_IN && PADDR_IN > 8'h14 |-> PRDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
endmodule : spcb_port_chk
bind spcb_port spcb_port_chk u_chk (.CLK_SYS_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
  .DATA_LINE_A_OE_OUT, .DATA_LINE_B_OE_OUT, .TX_INT_MASK_IN, .TX_INT_OUT);
`default_nettype wire

/* File: tb/spcb_codec.sv */
// model of the external serial device: clock, frame sync, data
// assumes the port shifts and samples on the rising serial clock
`timescale 1ns/1ps
`default_nettype none
module spcb_codec (
  output logic      sclk_out,
  output logic      fs_out,
  output logic      da_out,
  output logic      db_out,
  input  wire logic da_in,
  input  wire logic db_in
);
  logic [31:0] cap_a; // bits heard on line a
  logic [31:0] cap_b; // bits heard on line b
  // idle lines, clock parked low
  initial begin
    sclk_out = 1'h0;
    fs_out   = 1'h0;
    da_out   = 1'h0;
    db_out   = 1'h1;
  end
  // one framed word, clock runs inside it plus one trailing pulse after it
  task automatic frame(input int n, input logic [31:0] wa, input logic [31:0] wb);
    cap_a = 32'h0;
    cap_b = 32'h0;
    #37;
    fs_out = 1'h1; // sync stands with the first bit
    for (int i = n - 1; i >= 0; i--) begin
      da_out = wa[i];
      db_out = wb[i];
      #80 sclk_out = 1'h1;
      #80 sclk_out = 1'h0;
      fs_out = 1'h0;
      cap_a = {cap_a[30:0], da_in};
      cap_b = {cap_b[30:0], db_in};
    end
    da_out = ~da_out; // released line shows no stale bit
    db_out = ~db_out;
    #80 sclk_out = 1'h1;
    #80 sclk_out = 1'h0;
  endtask : frame
endmodule : spcb_codec
`default_nettype wire

/* File: tb/spcb_port_tb_top.sv */
// self-checking bench for the serial port control and buffer block
// assumes the codec model on the serial pins, apb master here
`timescale 1ns/1ps
`default_nettype none
module spcb_port_tb_top;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic        mask = 1'h0, rdy, sclk, fs, da_c, db_c, da_o, db_o, oe_a, oe_b, tint;
  logic [7:0]  padr = 8'h0;
  logic [31:0] pwd = 32'h0, prd, rd;
  int          error_cnt = 0, compares = 0, ints = 0;
  wire logic   da_w = oe_a ? da_o : da_c;
  wire logic   db_w = oe_b ? db_o : db_c;
  always #2.5 clk = ~clk;
  spcb_port u_spcb_port (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(rdy), .PSLVERR_OUT(), .SERIAL_BIT_CLOCK_IN(sclk), .FRAME_SYNC_LINE_IN(fs),
    .DATA_LINE_A_IN(da_w), .DATA_LINE_B_IN(db_w), .DATA_LINE_A_OUT(da_o),
    .DATA_LINE_A_OE_OUT(oe_a), .DATA_LINE_B_OUT(db_o), .DATA_LINE_B_OE_OUT(oe_b),
    .TX_INT_MASK_IN(mask), .TX_INT_OUT(tint));
  spcb_codec u_spcb_codec (.sclk_out(sclk), .fs_out(fs), .da_out(da_c), .db_out(db_c),
    .da_in(da_w), .db_in(db_w));
  // count transmit interrupt pulses
  always @(posedge clk) if (tint === 1'h1) ints <= ints + 1;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, read data taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    rd = prd;
    psel <= 1'h0;
    pen  <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc
  task automatic frm(input int n, input logic [31:0] wa, input logic [31:0] wb);
    u_spcb_codec.frame(n, wa, wb);
    @(posedge clk);
  endtask : frm
  // reset values, storage and unmapped space
  task automatic t_regs();
    rdc(spcb_pkg::OFF_CTL, spcb_pkg::CTL_RESET, "ctl reset");
    rdc(spcb_pkg::OFF_MCTL, spcb_pkg::MCTL_RESET, "mctl reset");
    apb(1'h1, spcb_pkg::OFF_MCTL, 32'hFFFFFFFF);
    rdc(spcb_pkg::OFF_MCTL, spcb_pkg::MCTL_WMASK, "mctl rw");
    apb(1'h1, spcb_pkg::OFF_CTL, 32'hFFFFFFFF);
    rdc(spcb_pkg::OFF_CTL, spcb_pkg::CTL_WMASK, "ctl rw");
    apb(1'h1, spcb_pkg::OFF_CTL, 32'h0);
    rdc(8'h18, 32'h0, "unmapped");
  endtask : t_regs
  // only the active buffer pair is touched while enabled
  // transmit both lines: plain, masked and lsb first, dma on
  task automatic t_tx();
    logic [31:0] cfg;
    logic [7:0]  ea, eb;
    for (int i = 0; i < 3; i++) begin
      cfg = 32'h03003071 | (i == 1 ? 32'h8 : 32'h0) | (i == 2 ? 32'h00140000 : 32'h0);
      mask <= (i == 1);
      ea = 8'hB1;
      eb = 8'h35;
      if (i == 1) ea = {<<{ea}};
      if (i == 1) eb = {<<{eb}};
      apb(1'h1, spcb_pkg::OFF_CTL, 32'h0);
      apb(1'h1, spcb_pkg::OFF_CTL, cfg);
      apb(1'h1, spcb_pkg::OFF_TX_A, 32'h000000B1);
      apb(1'h1, spcb_pkg::OFF_TX_B, 32'h00000035);
      rdc(spcb_pkg::OFF_CTL, cfg | 32'hD8000000, "tx full");
      ints = 0;
      frm(8, 32'h0, 32'h0);
      chk("tx line a", {24'h0, ea}, u_spcb_codec.cap_a);
      chk("tx line b", {24'h0, eb}, u_spcb_codec.cap_b);
      chk("tx int", 32'(i == 0), 32'(ints));
      chk("tx oe", 32'h3, {30'h0, oe_a, oe_b});
      rdc(spcb_pkg::OFF_CTL, cfg, "tx drained");
    end
    frm(8, 32'h0, 32'h0);
    rdc(spcb_pkg::OFF_CTL, cfg | 32'h24000000, "tx underflow");
    apb(1'h1, spcb_pkg::OFF_CTL, cfg & 32'hFEFFFFFE);
    rdc(spcb_pkg::OFF_CTL, cfg & 32'hFEFFFFFE, "tx err clear");
  endtask : t_tx
  // receive 16-bit words, then overrun the buffer
  task automatic t_rx();
    apb(1'h1, spcb_pkg::OFF_CTL, 32'h0);
    apb(1'h1, spcb_pkg::OFF_CTL, 32'h010030F1);
    frm(16, 32'h0000C3A5, 32'h00005A0F);
    rdc(spcb_pkg::OFF_CTL, 32'h910030F1, "rx part");
    rdc(spcb_pkg::OFF_RX_A, 32'h0000C3A5, "rx word a");
    rdc(spcb_pkg::OFF_RX_B, 32'h00005A0F, "rx word b");
    for (int k = 1; k < 4; k++) frm(16, 32'h1111 * k, 32'h2222 * k);
    rdc(spcb_pkg::OFF_CTL, 32'hFD0030F1, "rx overflow");
    rdc(spcb_pkg::OFF_RX_A, 32'h00001111, "rx oldest");
    rdc(spcb_pkg::OFF_RX_A, 32'h00003333, "rx overwrite");
    apb(1'h1, spcb_pkg::OFF_CTL, 32'h0);
    apb(1'h0, spcb_pkg::OFF_CTL, 32'h0);
    chk("rx err clear", 32'h0, rd & 32'h27FFFFFF);
  endtask : t_rx
  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  // main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_tx();
    t_rx();
    end_of_test();
  end
  // watchdog cuts a hang short
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
endmodule : spcb_port_tb_top
`default_nettype wire
